// ### aes128_block_crypto_engine.sv
// Block cipher engine: register port, key and state memories and sequencer.
`default_nettype none

// Operation
// - Encrypt or decrypt one block, AES-128.
// - Result ready 375 cycles after start.
// - Software selects encrypt or decrypt direction.
// - XOR mode combines written byte with stored.
// - Completion sets flag, interrupt if enabled.
// - Two sixteen-byte memories behind access registers.
// - Separate read/write pointers per memory, reset zero.
// - Each memory access advances its pointer.
// - Control register access zeroes all pointers.
// - Pointers wrap to zero after sixteen.
// - Pointers are invisible to software.
// - XOR-mode write advances both state pointers.
// - Memory accesses refused while running.
// - State memory holds input, working, output.
// - Key memory reads back last or original key.
// - DMA trigger pulses on completion.
// - Auto-start once state memory fully loaded.
// - Start bit runs, abort, self-clears.
// - Ready flag clears on first read or write-one.
// - Error on misaligned start or control access running.
// - Auto-start needs auto set, pointers zero.
module aes128_block_crypto_engine #(
   parameter int unsigned OP_CYCLES = aes_engine_pkg::OP_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic                              mclk,
   input  wire logic                              rst_n,
   // Register port
   input  wire logic [aes_engine_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                        reg_wdata,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   output logic      [7:0]                        reg_rdata,
   // Completion events
   output logic                                   irq,
   output logic                                   dma_trig
);
   import aes_engine_pkg::*;

   localparam int CNT_W = $clog2(OP_CYCLES);

   typedef struct packed {
      logic [15:0][7:0]    state_mem;
      logic [15:0][7:0]    key_mem;
      logic [3:0]          s_rptr;
      logic [3:0]          s_wptr;
      logic [3:0]          k_rptr;
      logic [3:0]          k_wptr;
      logic [3:0]          acc_cnt;
      logic                start;
      logic                auto_en;
      logic                decrypt;
      logic                xor_en;
      logic                ready;
      logic                error;
      logic [INTLVL_W-1:0] int_lvl;
      logic [CNT_W-1:0]    cnt;
      logic [7:0]          rcon;
      logic [7:0]          rdata;
      logic                irq;
      logic                dma;
   } eng_t;

   eng_t             st_reg;
   eng_t             st_next;
   logic [2:0]       idx;
   logic             hit;
   logic             ctrl_acc;
   logic             ctrl_wr;
   logic             stat_wr;
   logic             int_wr;
   logic             st_wr;
   logic             st_rd;
   logic             ky_wr;
   logic             ky_rd;
   logic             mem_acc;
   logic             start_req;
   logic             auto_hit;
   logic [7:0]       ctrl_view;
   logic [7:0]       xor_exp;
   logic [15:0][7:0] rnd_state;
   logic [15:0][7:0] rnd_key;

   // Address decode; only aligned words inside the eight-word window are mapped.
   assign idx      = reg_addr[4:2];
   assign hit      = (reg_addr[1:0] == 2'h0) && (reg_addr[ADDR_W-1:5] == '0);
   assign ctrl_acc = hit && (idx == IDX_CTRL) && (reg_wr || reg_rd);
   assign ctrl_wr  = hit && (idx == IDX_CTRL) && reg_wr;
   assign stat_wr  = hit && (idx == IDX_STATUS) && reg_wr;
   assign int_wr   = hit && (idx == IDX_INTCTRL) && reg_wr;
   assign mem_acc  = hit && (reg_wr || reg_rd) && ((idx == IDX_STATE) || (idx == IDX_KEY));

   // Memory ports are gated off while an operation runs.
   assign st_wr = hit && (idx == IDX_STATE) && reg_wr && !st_reg.start;
   assign st_rd = hit && (idx == IDX_STATE) && reg_rd && !st_reg.start;
   assign ky_wr = hit && (idx == IDX_KEY) && reg_wr && !st_reg.start;
   assign ky_rd = hit && (idx == IDX_KEY) && reg_rd && !st_reg.start;

   assign xor_exp = st_reg.state_mem[st_reg.s_wptr] ^ reg_wdata;

   // Round datapath; step 0 is the initial key addition, steps 1 to 10 are rounds.
   aes_round_step u_round (
      .decrypt      (st_reg.decrypt),
      .initial_step (st_reg.cnt == '0),
      .final_step   (st_reg.cnt == CNT_W'(LAST_STEP)),
      .rcon         (st_reg.rcon),
      .state_in     (st_reg.state_mem),
      .key_in       (st_reg.key_mem),
      .state_out    (rnd_state),
      .key_out      (rnd_key)
   );

   // Next-state logic for the whole engine.
   always_comb begin
      st_next       = st_reg;
      st_next.dma   = 1'b0;
      st_next.rdata = REG_RST;
      start_req     = 1'b0;
      ctrl_view     = REG_RST;
      ctrl_view[CTRL_START]   = st_reg.start;
      ctrl_view[CTRL_AUTO]    = st_reg.auto_en;
      ctrl_view[CTRL_DECRYPT] = st_reg.decrypt;
      ctrl_view[CTRL_XOR]     = st_reg.xor_en;

      // Software clears come first, so a hardware set in the same cycle wins.
      if (stat_wr) begin
         if (reg_wdata[STAT_ERROR]) st_next.error = 1'b0;
         if (reg_wdata[STAT_READY]) st_next.ready = 1'b0;
      end
      if (int_wr) begin
         st_next.int_lvl = reg_wdata[INTLVL_W-1:0];
      end

      // State memory writes, plain or XOR-combined.
      if (st_wr) begin
         if (st_reg.xor_en) begin
            st_next.state_mem[st_reg.s_wptr] = xor_exp;
            st_next.s_rptr = st_reg.s_rptr + 4'h1;
         end else begin
            st_next.state_mem[st_reg.s_wptr] = reg_wdata;
         end
         st_next.s_wptr  = st_reg.s_wptr + 4'h1;
         st_next.acc_cnt = st_reg.acc_cnt + 4'h1;
      end
      // Reading the first result byte retires the ready flag.
      if (st_rd) begin
         st_next.rdata   = st_reg.state_mem[st_reg.s_rptr];
         st_next.s_rptr  = st_reg.s_rptr + 4'h1;
         st_next.acc_cnt = st_reg.acc_cnt + 4'h1;
         if (st_reg.s_rptr == '0) st_next.ready = 1'b0;
      end
      // Key memory port; after a run it returns the other end of the schedule.
      if (ky_wr) begin
         st_next.key_mem[st_reg.k_wptr] = reg_wdata;
         st_next.k_wptr  = st_reg.k_wptr + 4'h1;
         st_next.acc_cnt = st_reg.acc_cnt + 4'h1;
      end
      if (ky_rd) begin
         st_next.rdata   = st_reg.key_mem[st_reg.k_rptr];
         st_next.k_rptr  = st_reg.k_rptr + 4'h1;
         st_next.acc_cnt = st_reg.acc_cnt + 4'h1;
      end

      // Plain register reads; pointers have no readable location.
      if (reg_rd && hit) begin
         case (idx)
            IDX_CTRL: begin
               st_next.rdata = ctrl_view;
            end
            IDX_STATUS: begin
               st_next.rdata[STAT_ERROR] = st_reg.error;
               st_next.rdata[STAT_READY] = st_reg.ready;
            end
            IDX_INTCTRL: begin
               st_next.rdata[INTLVL_W-1:0] = st_reg.int_lvl;
            end
            default: begin
            end
         endcase
      end

      // Control register: any access zeroes pointers; while running it aborts.
      if (ctrl_acc) begin
         st_next.s_rptr = '0;
         st_next.s_wptr = '0;
         st_next.k_rptr = '0;
         st_next.k_wptr = '0;
         if (st_reg.start) begin
            st_next.error = 1'b1;
            st_next.start = 1'b0;
         end else if (reg_wr) begin
            st_next.auto_en = reg_wdata[CTRL_AUTO];
            st_next.decrypt = reg_wdata[CTRL_DECRYPT];
            st_next.xor_en  = reg_wdata[CTRL_XOR];
            start_req       = reg_wdata[CTRL_START];
         end
      end

      // Auto-start on the sixteenth state byte with every pointer back at zero.
      auto_hit = st_reg.auto_en && st_wr && (st_reg.s_wptr == PTR_LAST) &&
                 (st_next.s_rptr == '0) && (st_next.k_rptr == '0) &&
                 (st_next.k_wptr == '0);

      // A start is only legal when accesses add up to whole blocks.
      if (start_req || auto_hit) begin
         if (st_next.acc_cnt != '0) begin
            st_next.error = 1'b1;
         end else begin
            st_next.start = 1'b1;
            st_next.cnt   = '0;
            st_next.rcon  = st_next.decrypt ? RCON_DEC_FIRST : RCON_ENC_FIRST;
         end
      end

      // Sequencer: eleven steps of work, then idle until the fixed latency ends.
      if (st_reg.start && !ctrl_acc) begin
         if (st_reg.cnt <= CNT_W'(LAST_STEP)) begin
            st_next.state_mem = rnd_state;
            st_next.key_mem   = rnd_key;
            if (st_reg.cnt != '0) begin
               if (st_reg.decrypt) begin
                  st_next.rcon = (st_reg.rcon == GF_POLY) ? RCON_TOP : (st_reg.rcon >> 1);
               end else begin
                  st_next.rcon = {st_reg.rcon[6:0], 1'b0} ^
                                 (st_reg.rcon[7] ? GF_POLY : REG_RST);
               end
            end
         end
         st_next.cnt = st_reg.cnt + 1'b1;
         if (st_reg.cnt == CNT_W'(OP_CYCLES - 1)) begin
            st_next.start = 1'b0;
            st_next.ready = 1'b1;
            st_next.dma   = 1'b1;
         end
      end

      // Software reset returns everything, memories included, to zero.
      if (ctrl_wr && !st_reg.start && reg_wdata[CTRL_RESET]) begin
         st_next = '0;
      end
      // The interrupt request is a level that follows the ready flag while int_lvl is nonzero.
      st_next.irq = st_next.ready && (st_next.int_lvl != '0);
   end

   // All state is one register.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign irq       = st_reg.irq;
   assign dma_trig  = st_reg.dma;

   // Checks on the engine's own behaviour.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // The latency is a parameter, so it is checked through the step counter, not a deep history.
   AST_LATENCY_375:
   assert property (st_reg.start && !ctrl_acc && (st_reg.cnt == CNT_W'(OP_CYCLES - 1))
                    |=> st_reg.dma && st_reg.ready && !st_reg.start)
      else $error("completion not at the end of the fixed latency");

   AST_START_FROM_ZERO:
   assert property ($rose(st_reg.start) |-> (st_reg.cnt == '0) &&
                    (st_reg.rcon == (st_reg.decrypt ? RCON_DEC_FIRST : RCON_ENC_FIRST)))
      else $error("operation did not begin at step zero");

   AST_START_HOLDS:
   assert property (st_reg.start && !ctrl_acc && (st_reg.cnt < CNT_W'(OP_CYCLES - 1))
                    |=> st_reg.start && !st_reg.dma)
      else $error("start bit dropped early");

   AST_DONE_FLAGS:
   assert property (st_reg.dma |-> st_reg.ready && !st_reg.start &&
                    (st_reg.irq == (st_reg.int_lvl != '0)))
      else $error("completion without ready flag or interrupt");

   AST_PTR_STEP:
   assert property (st_rd |=> st_reg.s_rptr == $past(st_reg.s_rptr) + 4'h1)
      else $error("state read pointer did not advance");

   AST_PTR_WRAP:
   assert property (ky_rd && (st_reg.k_rptr == PTR_LAST) |=> st_reg.k_rptr == '0)
      else $error("key read pointer did not wrap");

   AST_CTRL_CLEARS_PTRS:
   assert property (ctrl_acc |=> (st_reg.s_rptr == '0) && (st_reg.s_wptr == '0) &&
                    (st_reg.k_rptr == '0) && (st_reg.k_wptr == '0))
      else $error("pointers not cleared by control access");

   AST_REFUSED_RUNNING:
   assert property (st_reg.start && mem_acc |=> $stable(st_reg.s_wptr) &&
                    $stable(st_reg.k_rptr) && (st_reg.rdata == REG_RST))
      else $error("memory access taken while running");

   AST_XOR_DATA:
   assert property (st_wr && st_reg.xor_en
                    |=> st_reg.state_mem[$past(st_reg.s_wptr)] == $past(xor_exp))
      else $error("xor load wrong");

   AST_XOR_PTRS:
   assert property (st_wr && st_reg.xor_en |=> (st_reg.s_rptr == $past(st_reg.s_rptr) + 4'h1)
                    && (st_reg.s_wptr == $past(st_reg.s_wptr) + 4'h1))
      else $error("xor write did not move both pointers");

   AST_READY_CLEAR:
   assert property (st_rd && (st_reg.s_rptr == '0) |=> !st_reg.ready)
      else $error("ready flag not cleared by first byte read");

   AST_START_ERROR:
   assert property (ctrl_wr && reg_wdata[CTRL_START] && !st_reg.start &&
                    !reg_wdata[CTRL_RESET] && (st_reg.acc_cnt != '0)
                    |=> st_reg.error && !st_reg.start)
      else $error("misaligned start not flagged");

endmodule : aes128_block_crypto_engine
`default_nettype wire

// ### aes_engine_pkg.sv
// Constants shared by the block cipher engine and its round datapath.
`default_nettype none
package aes_engine_pkg;
   // Register port address width; byte address is four times the register index.
   localparam int         ADDR_W      = 8;
   localparam logic [2:0] IDX_CTRL    = 3'h0;
   localparam logic [2:0] IDX_STATUS  = 3'h1;
   localparam logic [2:0] IDX_STATE   = 3'h2;
   localparam logic [2:0] IDX_KEY     = 3'h3;
   localparam logic [2:0] IDX_INTCTRL = 3'h4;
   // Control and status field positions.
   localparam int         CTRL_START   = 7;
   localparam int         CTRL_AUTO    = 6;
   localparam int         CTRL_RESET   = 5;
   localparam int         CTRL_DECRYPT = 4;
   localparam int         CTRL_XOR     = 2;
   localparam int         STAT_ERROR   = 7;
   localparam int         STAT_READY   = 0;
   localparam int         INTLVL_W     = 2;
   // Reset and idle value of every register byte.
   localparam logic [7:0] REG_RST      = 8'h00;
   // Cycles from start to result, and the number of the last round step.
   localparam int unsigned OP_CYCLES_DEF = 375;
   localparam logic [3:0] LAST_STEP    = 4'hA;
   localparam logic [3:0] PTR_LAST     = 4'hF;
   // Round constant sequence and field arithmetic.
   localparam logic [7:0] RCON_ENC_FIRST = 8'h01;
   localparam logic [7:0] RCON_DEC_FIRST = 8'h36;
   localparam logic [7:0] RCON_TOP       = 8'h80;
   localparam logic [7:0] GF_POLY        = 8'h1B;
   localparam logic [7:0] SBOX_C         = 8'h63;
   localparam logic [7:0] ISBOX_C        = 8'h05;
   // Column mixing coefficients, element 0 applies to the byte's own row.
   localparam logic [3:0][7:0] MIX_ENC = {8'h01, 8'h01, 8'h03, 8'h02};
   localparam logic [3:0][7:0] MIX_DEC = {8'h09, 8'h0D, 8'h0B, 8'h0E};
endpackage : aes_engine_pkg
`default_nettype wire

// ### aes_round_step.sv
// One combinational cipher round step with its key schedule step.
`default_nettype none
module aes_round_step (
   // Step control
   input  wire logic             decrypt,
   input  wire logic             initial_step,
   input  wire logic             final_step,
   input  wire logic [7:0]       rcon,
   // Working data
   input  wire logic [15:0][7:0] state_in,
   input  wire logic [15:0][7:0] key_in,
   // Results
   output logic [15:0][7:0]      state_out,
   output logic [15:0][7:0]      key_out
);
   import aes_engine_pkg::*;

   logic [15:0][7:0] kn;
   logic [15:0][7:0] kp;
   logic [15:0][7:0] t;
   logic [15:0][7:0] m;
   logic [15:0][7:0] s;
   logic [3:0][7:0]  gf;
   logic [3:0][7:0]  gr;
   logic [3:0][7:0]  cf;

   function automatic logic [7:0] xtime(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : REG_RST);
   endfunction : xtime

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] r;
      logic [7:0] p;
      r = REG_RST;
      p = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) r = r ^ p;
         p = xtime(p);
      end
      return r;
   endfunction : gmul

   // Field inverse as a to the 254th power; zero maps to zero.
   function automatic logic [7:0] ginv(input logic [7:0] a);
      logic [7:0] r;
      logic [7:0] sq;
      r  = RCON_ENC_FIRST;
      sq = a;
      for (int i = 1; i < 8; i++) begin
         sq = gmul(sq, sq);
         r  = gmul(r, sq);
      end
      return r;
   endfunction : ginv

   function automatic logic [7:0] rotl(input logic [7:0] x, input int n);
      return (x << n) | (x >> (8 - n));
   endfunction : rotl

   // Substitution boxes computed, not tabled, to keep the source small.
   function automatic logic [7:0] sbox(input logic [7:0] x);
      logic [7:0] y;
      y = ginv(x);
      return y ^ rotl(y, 1) ^ rotl(y, 2) ^ rotl(y, 3) ^ rotl(y, 4) ^ SBOX_C;
   endfunction : sbox

   function automatic logic [7:0] isbox(input logic [7:0] x);
      return ginv(rotl(x, 1) ^ rotl(x, 3) ^ rotl(x, 6) ^ ISBOX_C);
   endfunction : isbox

   // Forward key step for encryption, backward key step for decryption.
   always_comb begin
      for (int j = 0; j < 4; j++) begin
         gf[j] = sbox(key_in[12 + (j + 1) % 4]) ^ ((j == 0) ? rcon : REG_RST);
      end
      for (int i = 0; i < 4; i++) kn[i] = key_in[i] ^ gf[i];
      for (int i = 4; i < 16; i++) kn[i] = key_in[i] ^ kn[i - 4];
      for (int i = 4; i < 16; i++) kp[i] = key_in[i] ^ key_in[i - 4];
      for (int j = 0; j < 4; j++) begin
         gr[j] = sbox(kp[12 + (j + 1) % 4]) ^ ((j == 0) ? rcon : REG_RST);
      end
      for (int i = 0; i < 4; i++) kp[i] = key_in[i] ^ gr[i];
   end

   // Substitution, row shift and column mixing in the chosen direction.
   always_comb begin
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 4; c++) begin
            t[r + 4 * c] = decrypt ? isbox(state_in[r + 4 * ((c + 4 - r) % 4)])
                                   : sbox(state_in[r + 4 * ((c + r) % 4)]);
         end
      end
      if (decrypt) t = t ^ kp;
      cf = decrypt ? MIX_DEC : MIX_ENC;
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 4; i++) begin
            m[4 * c + i] = REG_RST;
            for (int j = 0; j < 4; j++) begin
               m[4 * c + i] = m[4 * c + i] ^ gmul(t[4 * c + (i + j) % 4], cf[j]);
            end
         end
      end
      s = final_step ? t : m;
      if (initial_step) begin
         state_out = state_in ^ key_in;
         key_out   = key_in;
      end else begin
         state_out = decrypt ? s : (s ^ kn);
         key_out   = decrypt ? kp : kn;
      end
   end
endmodule : aes_round_step
`default_nettype wire

// ### reg_host.sv
// Host model for the register port: single-cycle write and read strobes.
`default_nettype none
module reg_host (
   // Clock
   input  wire logic       mclk,
   // Register port
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero.
   initial begin
      reg_addr  = 8'hFF;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // One write; address and data are inverted once released so stale values never match.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // One read; the data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask : rd

   // Sixteen sequential bytes, byte 0 being the most significant of the block.
   task automatic load16(input logic [7:0] a, input logic [127:0] v);
      for (int i = 0; i < 16; i++) begin
         wr(a, v[127-8*i -: 8]);
      end
   endtask : load16

   task automatic read16(input logic [7:0] a, output logic [127:0] v);
      for (int i = 0; i < 16; i++) begin
         rd(a, v[127-8*i -: 8]);
      end
   endtask : read16
endmodule : reg_host
`default_nettype wire

// ### testbench.sv
// Self-checking testbench of the block cipher engine.
`default_nettype none
`define CHECK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
         num_errors++; \
      end \
   end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import aes_engine_pkg::*;
   // A short latency keeps the run brief; expectations follow it.
   localparam int unsigned  OPC = 20;
   localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
   localparam logic [127:0] PT  = 128'h00112233445566778899AABBCCDDEEFF;
   localparam logic [127:0] CT  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
   localparam logic [127:0] RK  = 128'h13111D7FE3944A17F307A78B4D2B30C5;
   localparam logic [7:0]   A_CTRL  = {3'h0, IDX_CTRL, 2'h0};
   localparam logic [7:0]   A_STAT  = {3'h0, IDX_STATUS, 2'h0};
   localparam logic [7:0]   A_STATE = {3'h0, IDX_STATE, 2'h0};
   localparam logic [7:0]   A_KEY   = {3'h0, IDX_KEY, 2'h0};
   localparam logic [7:0]   A_INT   = {3'h0, IDX_INTCTRL, 2'h0};

   logic         mclk;
   logic         rst_n;
   logic [7:0]   reg_addr;
   logic [7:0]   reg_wdata;
   logic         reg_wr;
   logic         reg_rd;
   logic [7:0]   reg_rdata;
   logic         irq;
   logic         dma_trig;
   logic [7:0]   d;
   logic [127:0] blk;
   int           n;
   int           num_errors;
   int           samples_checked;
   int           cyc = 0;

   aes128_block_crypto_engine #(.OP_CYCLES(OPC)) aes128_block_crypto_engine_i (
      .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .dma_trig(dma_trig));

   reg_host reg_host_i (
      .mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   // A hang is cut short well above the expected run length.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic expect_rd(input logic [7:0] a, input logic [7:0] e, input string what);
      reg_host_i.rd(a, d);
      `CHECK(what, e, d)
   endtask : expect_rd

   // Counts cycles after a start until the completion pulse, bounded by lim.
   task automatic wait_done(input int lim);
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (dma_trig !== 1'b1 && n < lim);
   endtask : wait_done

   task automatic t_reset();
      `CHECK("irq", 1'b0, irq)
      expect_rd(A_CTRL, 8'h00, "ctrl");
      expect_rd(A_STAT, 8'h00, "status");
      expect_rd(A_INT, 8'h00, "intctrl");
      for (int a = 8'h14; a <= 8'h1C; a += 4) begin
         expect_rd(8'(a), 8'h00, "reserved");
      end
      expect_rd(8'h09, 8'h00, "unaligned");
   endtask : t_reset

   task automatic t_encrypt();
      reg_host_i.wr(A_INT, 8'h01);
      reg_host_i.wr(A_CTRL, 8'h00);
      reg_host_i.load16(A_KEY, KEY);
      reg_host_i.load16(A_STATE, PT);
      reg_host_i.wr(A_CTRL, 8'h80);
      wait_done(2 * OPC);
      `CHECK("latency", OPC, n)
      `CHECK("irq", 1'b1, irq)
      expect_rd(A_STAT, 8'h01, "ready");
      reg_host_i.read16(A_STATE, blk);
      `CHECK("cipher", CT, blk)
      expect_rd(A_STAT, 8'h00, "ready clear");
      `CHECK("irq", 1'b0, irq)
      reg_host_i.read16(A_KEY, blk);
      `CHECK("last subkey", RK, blk)
   endtask : t_encrypt

   task automatic t_decrypt_xor();
      reg_host_i.wr(A_CTRL, 8'h10);
      reg_host_i.load16(A_KEY, RK);
      reg_host_i.load16(A_STATE, CT);
      reg_host_i.wr(A_CTRL, 8'h90);
      wait_done(2 * OPC);
      `CHECK("latency", OPC, n)
      reg_host_i.read16(A_STATE, blk);
      `CHECK("plain", PT, blk)
      reg_host_i.read16(A_KEY, blk);
      `CHECK("original key", KEY, blk)
      // XOR load: the write also moves the read pointer on to byte 1.
      reg_host_i.wr(A_CTRL, 8'h04);
      reg_host_i.wr(A_STATE, 8'h5A);
      expect_rd(A_STATE, PT[119:112], "xor read pointer");
      // Byte 1 is not zero, so a plain overwrite there would show.
      reg_host_i.wr(A_STATE, 8'h5A);
      reg_host_i.wr(A_CTRL, 8'h04);
      reg_host_i.read16(A_STATE, blk);
      `CHECK("xor state", {8'h5A, PT[119:112] ^ 8'h5A, PT[111:0]}, blk)
      expect_rd(A_STATE, 8'h5A, "wrapped byte");
   endtask : t_decrypt_xor

   task automatic t_errors();
      reg_host_i.wr(A_CTRL, 8'h20);
      reg_host_i.wr(A_KEY, 8'h11);
      reg_host_i.wr(A_CTRL, 8'h80);
      expect_rd(A_STAT, 8'h80, "misaligned start");
      expect_rd(A_CTRL, 8'h00, "not started");
      reg_host_i.wr(A_STAT, 8'h80);
      expect_rd(A_STAT, 8'h00, "error clear");
      // Accesses during a run are refused, and a control read aborts it.
      reg_host_i.wr(A_CTRL, 8'h20);
      reg_host_i.load16(A_KEY, KEY);
      reg_host_i.load16(A_STATE, PT);
      reg_host_i.wr(A_CTRL, 8'h80);
      reg_host_i.wr(A_STATE, 8'hFF);
      expect_rd(A_STATE, 8'h00, "busy state");
      reg_host_i.rd(A_CTRL, d);
      expect_rd(A_STAT, 8'h80, "busy ctrl");
      wait_done(OPC + 5);
      `CHECK("aborted trigger", 1'b0, dma_trig)
      expect_rd(A_CTRL, 8'h00, "aborted start");
   endtask : t_errors

   task automatic t_auto();
      reg_host_i.wr(A_CTRL, 8'h20);
      reg_host_i.wr(A_INT, 8'h00);
      reg_host_i.wr(A_CTRL, 8'h40);
      reg_host_i.load16(A_KEY, KEY);
      reg_host_i.load16(A_STATE, PT);
      wait_done(2 * OPC);
      `CHECK("auto done", 1'b1, dma_trig)
      `CHECK("irq masked", 1'b0, irq)
      reg_host_i.wr(A_STAT, 8'h01);
      expect_rd(A_STAT, 8'h00, "ready write clear");
      reg_host_i.read16(A_STATE, blk);
      `CHECK("auto cipher", CT, blk)
   endtask : t_auto

   // Main sequence.
   initial begin
      rst_n           = 1'b0;
      num_errors      = 0;
      samples_checked = 0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_encrypt();
      t_decrypt_xor();
      t_errors();
      t_auto();
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
